// ===== core/atb_trim_bank.sv
// Read-only trim coefficient bank of the auxiliary converter
//
// Notes on behaviour
// - Offset 0xB0 bits 5:0 show offset first-order coefficient bits 11:6.
// - Offset 0xB0 bits 7:6 show offset second-order coefficient bits 1:0.
// - Offset 0xB1 bits 7:0 show offset second-order coefficient bits 9:2.
// - Offset 0xB2 bits 1:0 show offset second-order bits 11:10, bits 7:2 spare.
// - Offset 0xB3 bits 7:0 show gain zero-order coefficient bits 7:0.
// - Offset 0xB4 bits 6:0 show gain zero-order coefficient bits 14:8.
// - Offset 0xB4 bit 7 shows gain first-order coefficient bit 0.
// - Offset 0xB5 bits 7:0 show gain first-order coefficient bits 8:1.
// - Offset 0xB6 bits 4:0 show gain first-order coefficient bits 13:9.
// - Offset 0xB6 bits 7:5 show gain second-order coefficient bits 2:0.
// - Offset 0xAF bits 7:2 show offset first-order coefficient bits 5:0.
// - Offset 0xB7 bits 7:0 show gain second-order coefficient bits 10:3.
`timescale 1ns/1ps
module atb_trim_bank #(
    parameter int unsigned AW = atb_pkg::ATB_ADDR_W,
    parameter int unsigned DW = atb_pkg::ATB_DATA_W
) (
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_rst_n,
    input  wire logic [AW-1:0]                  i_addr,
    input  wire logic [DW-1:0]                  i_wr_data,
    input  wire logic                           i_wr_stb,
    input  wire logic                           i_rd_stb,
    output logic      [DW-1:0]                  o_rd_data,
    input  wire logic                           i_trim_load,
    input  wire logic [atb_pkg::ATB_OT1_W-1:0]  i_offset_tempco_order1,
    input  wire logic [atb_pkg::ATB_OT2_W-1:0]  i_offset_tempco_order2,
    input  wire logic [atb_pkg::ATB_GT0_W-1:0]  i_gain_tempco_order0,
    input  wire logic [atb_pkg::ATB_GT1_W-1:0]  i_gain_tempco_order1,
    input  wire logic [atb_pkg::ATB_GT2_W-1:0]  i_gain_tempco_order2,
    output logic      [atb_pkg::ATB_OT1_W-1:0]  o_offset_tempco_order1,
    output logic      [atb_pkg::ATB_OT2_W-1:0]  o_offset_tempco_order2,
    output logic      [atb_pkg::ATB_GT0_W-1:0]  o_gain_tempco_order0,
    output logic      [atb_pkg::ATB_GT1_W-1:0]  o_gain_tempco_order1,
    output logic      [atb_pkg::ATB_GT2_W-1:0]  o_gain_tempco_order2,
    output logic                                o_trim_loaded,
    output logic                                o_wr_rejected
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [atb_pkg::ATB_OT1_W-1:0]   ot1;
    logic [atb_pkg::ATB_OT2_W-1:0]   ot2;
    logic [atb_pkg::ATB_GT0_W-1:0]   gt0;
    logic [atb_pkg::ATB_GT1_W-1:0]   gt1;
    logic [atb_pkg::ATB_GT2_W-1:0]   gt2;
    logic [DW-1:0]                   img [atb_pkg::ATB_NUM_REGS];
    logic [atb_pkg::ATB_IDX_W-1:0]   idx;
    logic                            hit;
    logic [DW-1:0]                   sel_data;
    logic                            trim_loaded_q;
    logic                            wr_rejected_q;

    // ************************************************************
    // Coefficient storage
    // ************************************************************
    // Trim arrives from fuse shadow logic on this clock, so no sync stage
    atb_coef_hold #(.W(atb_pkg::ATB_OT1_W)) u_hold_ot1 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (i_trim_load),
        .i_value   (i_offset_tempco_order1),
        .o_value   (ot1)
    );

    atb_coef_hold #(.W(atb_pkg::ATB_OT2_W)) u_hold_ot2 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (i_trim_load),
        .i_value   (i_offset_tempco_order2),
        .o_value   (ot2)
    );

    atb_coef_hold #(.W(atb_pkg::ATB_GT0_W)) u_hold_gt0 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (i_trim_load),
        .i_value   (i_gain_tempco_order0),
        .o_value   (gt0)
    );

    atb_coef_hold #(.W(atb_pkg::ATB_GT1_W)) u_hold_gt1 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (i_trim_load),
        .i_value   (i_gain_tempco_order1),
        .o_value   (gt1)
    );

    atb_coef_hold #(.W(atb_pkg::ATB_GT2_W)) u_hold_gt2 (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (i_trim_load),
        .i_value   (i_gain_tempco_order2),
        .o_value   (gt2)
    );

    assign o_offset_tempco_order1 = ot1;
    assign o_offset_tempco_order2 = ot2;
    assign o_gain_tempco_order0   = gt0;
    assign o_gain_tempco_order1   = gt1;
    assign o_gain_tempco_order2   = gt2;

    // ************************************************************
    // Register images
    // ************************************************************
    // Every image starts from the spare fill so unused bits read zero
    always_comb begin
        for (int i = 0; i < int'(atb_pkg::ATB_NUM_REGS); i++) begin
            img[i] = atb_pkg::ATB_SPARE_FILL;
        end
        img[0][atb_pkg::ATB_AF_OT1_RLSB +: atb_pkg::ATB_AF_OT1_LEN] =
            ot1[atb_pkg::ATB_AF_OT1_CLSB +: atb_pkg::ATB_AF_OT1_LEN];
        img[1][atb_pkg::ATB_B0_OT1_RLSB +: atb_pkg::ATB_B0_OT1_LEN] =
            ot1[atb_pkg::ATB_B0_OT1_CLSB +: atb_pkg::ATB_B0_OT1_LEN];
        img[1][atb_pkg::ATB_B0_OT2_RLSB +: atb_pkg::ATB_B0_OT2_LEN] =
            ot2[atb_pkg::ATB_B0_OT2_CLSB +: atb_pkg::ATB_B0_OT2_LEN];
        img[2][atb_pkg::ATB_B1_OT2_RLSB +: atb_pkg::ATB_B1_OT2_LEN] =
            ot2[atb_pkg::ATB_B1_OT2_CLSB +: atb_pkg::ATB_B1_OT2_LEN];
        img[3][atb_pkg::ATB_B2_OT2_RLSB +: atb_pkg::ATB_B2_OT2_LEN] =
            ot2[atb_pkg::ATB_B2_OT2_CLSB +: atb_pkg::ATB_B2_OT2_LEN];
        img[4][atb_pkg::ATB_B3_GT0_RLSB +: atb_pkg::ATB_B3_GT0_LEN] =
            gt0[atb_pkg::ATB_B3_GT0_CLSB +: atb_pkg::ATB_B3_GT0_LEN];
        img[5][atb_pkg::ATB_B4_GT0_RLSB +: atb_pkg::ATB_B4_GT0_LEN] =
            gt0[atb_pkg::ATB_B4_GT0_CLSB +: atb_pkg::ATB_B4_GT0_LEN];
        img[5][atb_pkg::ATB_B4_GT1_RLSB +: atb_pkg::ATB_B4_GT1_LEN] =
            gt1[atb_pkg::ATB_B4_GT1_CLSB +: atb_pkg::ATB_B4_GT1_LEN];
        img[6][atb_pkg::ATB_B5_GT1_RLSB +: atb_pkg::ATB_B5_GT1_LEN] =
            gt1[atb_pkg::ATB_B5_GT1_CLSB +: atb_pkg::ATB_B5_GT1_LEN];
        img[7][atb_pkg::ATB_B6_GT1_RLSB +: atb_pkg::ATB_B6_GT1_LEN] =
            gt1[atb_pkg::ATB_B6_GT1_CLSB +: atb_pkg::ATB_B6_GT1_LEN];
        img[7][atb_pkg::ATB_B6_GT2_RLSB +: atb_pkg::ATB_B6_GT2_LEN] =
            gt2[atb_pkg::ATB_B6_GT2_CLSB +: atb_pkg::ATB_B6_GT2_LEN];
        img[8][atb_pkg::ATB_B7_GT2_RLSB +: atb_pkg::ATB_B7_GT2_LEN] =
            gt2[atb_pkg::ATB_B7_GT2_CLSB +: atb_pkg::ATB_B7_GT2_LEN];
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    // Offset 0xAF bits 1:0 and the top bits of the gain second-order word
    // belong to neighbouring banks and are not driven from here
    assign hit = (i_addr >= atb_pkg::ATB_FIRST_ADDR) &&
                 (i_addr <= atb_pkg::ATB_LAST_ADDR);
    assign idx = atb_pkg::ATB_IDX_W'(i_addr - atb_pkg::ATB_FIRST_ADDR);

    always_comb begin
        sel_data = atb_pkg::ATB_RD_IDLE;
        if (hit) begin
            sel_data = img[idx];
        end
    end

    atb_read_port #(.DW(DW)) u_read_port (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_rd_stb  (i_rd_stb),
        .i_hit     (hit),
        .i_data    (sel_data),
        .o_rd_data (o_rd_data)
    );

    // ************************************************************
    // Status
    // ************************************************************
    // Sticky until reset: trim is loaded once per power-up
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            trim_loaded_q <= 1'b0;
        end else if (i_trim_load) begin
            trim_loaded_q <= 1'b1;
        end
    end

    // Writes are dropped; this pulse lets software debug spot stray writes
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_rejected_q <= 1'b0;
        end else begin
            // Write data are ignored on purpose: the bank has nothing to store them in
            wr_rejected_q <= i_wr_stb && hit;
        end
    end

    assign o_trim_loaded = trim_loaded_q;
    assign o_wr_rejected = wr_rejected_q;

endmodule // atb_trim_bank

// ===== core/atb_pkg.sv
// Constants for the auxiliary converter trim coefficient bank
package atb_pkg;

    // ************************************************************
    // Bus and storage widths
    // ************************************************************
    localparam int unsigned ATB_ADDR_W   = 8;
    localparam int unsigned ATB_DATA_W   = 8;
    localparam int unsigned ATB_NUM_REGS = 9;
    localparam int unsigned ATB_IDX_W    = 4;

    // Coefficient widths
    localparam int unsigned ATB_OT1_W = 12;
    localparam int unsigned ATB_OT2_W = 12;
    localparam int unsigned ATB_GT0_W = 15;
    localparam int unsigned ATB_GT1_W = 14;
    localparam int unsigned ATB_GT2_W = 14;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ATB_AUX_OFFSET_TRIM_WORD_11   = 8'haf;
    localparam logic [7:0] ATB_AUX_OFFSET_TRIM_WORD_12   = 8'hb0;
    localparam logic [7:0] ATB_AUX_OFFSET_TRIM_WORD_13   = 8'hb1;
    localparam logic [7:0] ATB_AUX_OFFSET_TRIM_WORD_14   = 8'hb2;
    localparam logic [7:0] ATB_AUX_CELL_GAIN_TRIM_WORD_1 = 8'hb3;
    localparam logic [7:0] ATB_AUX_CELL_GAIN_TRIM_WORD_2 = 8'hb4;
    localparam logic [7:0] ATB_AUX_CELL_GAIN_TRIM_WORD_3 = 8'hb5;
    localparam logic [7:0] ATB_AUX_CELL_GAIN_TRIM_WORD_4 = 8'hb6;
    localparam logic [7:0] ATB_AUX_CELL_GAIN_TRIM_WORD_5 = 8'hb7;
    localparam logic [7:0] ATB_FIRST_ADDR = ATB_AUX_OFFSET_TRIM_WORD_11;
    localparam logic [7:0] ATB_LAST_ADDR  = ATB_AUX_CELL_GAIN_TRIM_WORD_5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] ATB_REG_RESET  = 8'h00;
    localparam logic [7:0] ATB_RD_IDLE    = 8'h00;
    localparam logic [7:0] ATB_SPARE_FILL = 8'h00;

    // ************************************************************
    // Field positions: register lsb, coefficient lsb, length
    // ************************************************************
    localparam int unsigned ATB_AF_OT1_RLSB = 2;
    localparam int unsigned ATB_AF_OT1_CLSB = 0;
    localparam int unsigned ATB_AF_OT1_LEN  = 6;
    localparam int unsigned ATB_B0_OT1_RLSB = 0;
    localparam int unsigned ATB_B0_OT1_CLSB = 6;
    localparam int unsigned ATB_B0_OT1_LEN  = 6;
    localparam int unsigned ATB_B0_OT2_RLSB = 6;
    localparam int unsigned ATB_B0_OT2_CLSB = 0;
    localparam int unsigned ATB_B0_OT2_LEN  = 2;
    localparam int unsigned ATB_B1_OT2_RLSB = 0;
    localparam int unsigned ATB_B1_OT2_CLSB = 2;
    localparam int unsigned ATB_B1_OT2_LEN  = 8;
    localparam int unsigned ATB_B2_OT2_RLSB = 0;
    localparam int unsigned ATB_B2_OT2_CLSB = 10;
    localparam int unsigned ATB_B2_OT2_LEN  = 2;
    localparam int unsigned ATB_B3_GT0_RLSB = 0;
    localparam int unsigned ATB_B3_GT0_CLSB = 0;
    localparam int unsigned ATB_B3_GT0_LEN  = 8;
    localparam int unsigned ATB_B4_GT0_RLSB = 0;
    localparam int unsigned ATB_B4_GT0_CLSB = 8;
    localparam int unsigned ATB_B4_GT0_LEN  = 7;
    localparam int unsigned ATB_B4_GT1_RLSB = 7;
    localparam int unsigned ATB_B4_GT1_CLSB = 0;
    localparam int unsigned ATB_B4_GT1_LEN  = 1;
    localparam int unsigned ATB_B5_GT1_RLSB = 0;
    localparam int unsigned ATB_B5_GT1_CLSB = 1;
    localparam int unsigned ATB_B5_GT1_LEN  = 8;
    localparam int unsigned ATB_B6_GT1_RLSB = 0;
    localparam int unsigned ATB_B6_GT1_CLSB = 9;
    localparam int unsigned ATB_B6_GT1_LEN  = 5;
    localparam int unsigned ATB_B6_GT2_RLSB = 5;
    localparam int unsigned ATB_B6_GT2_CLSB = 0;
    localparam int unsigned ATB_B6_GT2_LEN  = 3;
    localparam int unsigned ATB_B7_GT2_RLSB = 0;
    localparam int unsigned ATB_B7_GT2_CLSB = 3;
    localparam int unsigned ATB_B7_GT2_LEN  = 8;

endpackage

// ===== core/atb_coef_hold.sv
// Holding register for one trim coefficient
`timescale 1ns/1ps
module atb_coef_hold #(
    parameter int unsigned W = 12
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic      [W-1:0] o_value
);

    logic [W-1:0] value_q;

    // ************************************************************
    // Capture
    // ************************************************************
    // Only the trim load path and reset change the value; the bus cannot reach it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            value_q <= '0;
        end else if (i_load) begin
            value_q <= i_value;
        end
    end

    assign o_value = value_q;

endmodule // atb_coef_hold

// ===== core/atb_read_port.sv
// Registered read data stage of the trim bank
`timescale 1ns/1ps
module atb_read_port #(
    parameter int unsigned DW = 8
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_rd_stb,
    input  wire logic          i_hit,
    input  wire logic [DW-1:0] i_data,
    output logic      [DW-1:0] o_rd_data
);

    logic [DW-1:0] rd_data_q;

    // ************************************************************
    // Read data
    // ************************************************************
    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rd_data_q <= '0;
        end else if (i_rd_stb && i_hit) begin
            rd_data_q <= i_data;
        end else begin
            rd_data_q <= '0;
        end
    end

    assign o_rd_data = rd_data_q;

endmodule // atb_read_port

// ===== tb/atb_trim_bank_asserts.sv
// Concurrent checks on the trim coefficient bank ports
`timescale 1ns/1ps
module atb_trim_bank_asserts (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic        i_wr_stb,
    input wire logic        i_rd_stb,
    input wire logic [7:0]  o_rd_data,
    input wire logic        i_trim_load,
    input wire logic [11:0] i_offset_tempco_order1,
    input wire logic [11:0] i_offset_tempco_order2,
    input wire logic [14:0] i_gain_tempco_order0,
    input wire logic [13:0] i_gain_tempco_order1,
    input wire logic [13:0] i_gain_tempco_order2,
    input wire logic [11:0] o_offset_tempco_order1,
    input wire logic [11:0] o_offset_tempco_order2,
    input wire logic [14:0] o_gain_tempco_order0,
    input wire logic [13:0] o_gain_tempco_order1,
    input wire logic [13:0] o_gain_tempco_order2,
    input wire logic        o_wr_rejected
);
    wire logic [11:0] ot1     = o_offset_tempco_order1;
    wire logic [11:0] ot2     = o_offset_tempco_order2;
    wire logic [14:0] gt0     = o_gain_tempco_order0;
    wire logic [13:0] gt1     = o_gain_tempco_order1;
    wire logic [13:0] gt2     = o_gain_tempco_order2;
    wire logic [66:0] coef    = {gt2, gt1, gt0, ot2, ot1};
    wire logic [66:0] coef_in = {i_gain_tempco_order2, i_gain_tempco_order1,
                                 i_gain_tempco_order0, i_offset_tempco_order2,
                                 i_offset_tempco_order1};
    // Address 0x00 is unmapped, so it doubles as the no-read marker
    wire logic [7:0]  ra      = i_rd_stb ? i_addr : 8'h00;
    wire logic        wr_hit  = i_wr_stb && i_addr >= 8'haf && i_addr <= 8'hb7;

    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_rd_af_fields: assert property (ra == 8'haf |=>
        o_rd_data == {$past(ot1[5:0]), 2'b00}) else $error("read of af wrong");
    a_rd_b0_fields: assert property (ra == 8'hb0 |=>
        o_rd_data == {$past(ot2[1:0]), $past(ot1[11:6])}) else $error("read of b0 wrong");
    a_rd_b1_fields: assert property (ra == 8'hb1 |=>
        o_rd_data == $past(ot2[9:2])) else $error("read of b1 wrong");
    a_rd_b2_fields: assert property (ra == 8'hb2 |=>
        o_rd_data == {6'h00, $past(ot2[11:10])}) else $error("read of b2 wrong");
    a_rd_b3_fields: assert property (ra == 8'hb3 |=>
        o_rd_data == $past(gt0[7:0])) else $error("read of b3 wrong");
    a_rd_b4_fields: assert property (ra == 8'hb4 |=>
        o_rd_data == {$past(gt1[0]), $past(gt0[14:8])}) else $error("read of b4 wrong");
    a_rd_b5_fields: assert property (ra == 8'hb5 |=>
        o_rd_data == $past(gt1[8:1])) else $error("read of b5 wrong");
    a_rd_b6_fields: assert property (ra == 8'hb6 |=>
        o_rd_data == {$past(gt2[2:0]), $past(gt1[13:9])}) else $error("read of b6 wrong");
    a_rd_b7_fields: assert property (ra == 8'hb7 |=>
        o_rd_data == $past(gt2[10:3])) else $error("read of b7 wrong");
    a_coef_hold: assert property (!i_trim_load |=>
        $stable(coef)) else $error("coefficients moved without a load");
    a_load_capture: assert property (i_trim_load |=>
        coef == $past(coef_in)) else $error("load not captured");
    a_rd_idle_zero: assert property (!i_rd_stb |=>
        o_rd_data == 8'h00) else $error("read data not zero when idle");
    a_wr_flag: assert property (wr_hit |=>
        o_wr_rejected) else $error("write not flagged as rejected");

    c_load_read: cover property (i_trim_load ##2 ra == 8'hac);
    c_wr_reject: cover property (wr_hit ##1 o_wr_rejected);
    c_rd_b0: cover property (ra == 8'hb0 ##1 o_rd_data != 8'h00);
endmodule // atb_trim_bank_asserts

bind atb_trim_bank atb_trim_bank_asserts atb_trim_bank_asserts_inst (
    .i_sys_clk, .i_rst_n, .i_addr, .i_wr_stb, .i_rd_stb, .o_rd_data, .i_trim_load,
    .i_offset_tempco_order1, .i_offset_tempco_order2, .i_gain_tempco_order0,
    .i_gain_tempco_order1, .i_gain_tempco_order2, .o_offset_tempco_order1,
    .o_offset_tempco_order2, .o_gain_tempco_order0, .o_gain_tempco_order1,
    .o_gain_tempco_order2, .o_wr_rejected
);

// ===== tb/atb_trim_bank_tb_top.sv
// Self-checking bench for the trim coefficient bank
`timescale 1ns/1ps
module atb_trim_bank_tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wr_data = 8'h00;
    logic        i_wr_stb = 1'b0;
    logic        i_rd_stb = 1'b0;
    logic        i_trim_load = 1'b0;
    logic [11:0] i_offset_tempco_order1 = 12'h000;
    logic [11:0] i_offset_tempco_order2 = 12'h000;
    logic [14:0] i_gain_tempco_order0 = 15'h0000;
    logic [13:0] i_gain_tempco_order1 = 14'h0000;
    logic [13:0] i_gain_tempco_order2 = 14'h0000;
    logic [7:0]  o_rd_data;
    logic [11:0] o_offset_tempco_order1, o_offset_tempco_order2, e_ot1 = '0, e_ot2 = '0;
    logic [14:0] o_gain_tempco_order0, e_gt0 = '0;
    logic [13:0] o_gain_tempco_order1, o_gain_tempco_order2, e_gt1 = '0, e_gt2 = '0;
    logic        o_trim_loaded;
    logic        o_wr_rejected;
    int          bad_count = 0;
    int          n_checks = 0;

    atb_trim_bank atb_trim_bank_inst (
        .i_sys_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
        .i_trim_load, .i_offset_tempco_order1, .i_offset_tempco_order2,
        .i_gain_tempco_order0, .i_gain_tempco_order1, .i_gain_tempco_order2,
        .o_offset_tempco_order1, .o_offset_tempco_order2, .o_gain_tempco_order0,
        .o_gain_tempco_order1, .o_gain_tempco_order2, .o_trim_loaded, .o_wr_rejected
    );

    initial forever #12.5 i_sys_clk = ~i_sys_clk;

    // Register image built from the held coefficients
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        case (a)
            8'haf: return {e_ot1[5:0], 2'b00};
            8'hb0: return {e_ot2[1:0], e_ot1[11:6]};
            8'hb1: return e_ot2[9:2];
            8'hb2: return {6'h00, e_ot2[11:10]};
            8'hb3: return e_gt0[7:0];
            8'hb4: return {e_gt1[0], e_gt0[14:8]};
            8'hb5: return e_gt1[8:1];
            8'hb6: return {e_gt2[2:0], e_gt1[13:9]};
            8'hb7: return e_gt2[10:3];
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b1;
        i_addr   <= a;
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b0;
        #1 check(o_rd_data, exp_reg(a));
    endtask

    task automatic wr(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_wr_stb  <= 1'b1;
        i_addr    <= a;
        i_wr_data <= 8'($urandom);
        @(posedge i_sys_clk);
        i_wr_stb <= 1'b0;
        #1 check({7'h00, o_wr_rejected}, {7'h00, a >= 8'haf && a <= 8'hb7});
    endtask

    // Inputs are scrambled after each load so a missed hold shows up in reads
    task automatic load(input logic [95:0] r);
        @(posedge i_sys_clk);
        i_trim_load <= 1'b1;
        {i_gain_tempco_order2, i_gain_tempco_order1, i_gain_tempco_order0,
         i_offset_tempco_order2, i_offset_tempco_order1} <= r[66:0];
        {e_gt2, e_gt1, e_gt0, e_ot2, e_ot1} = r[66:0];
        @(posedge i_sys_clk);
        i_trim_load <= 1'b0;
        {i_gain_tempco_order2, i_gain_tempco_order1, i_gain_tempco_order0,
         i_offset_tempco_order2, i_offset_tempco_order1} <= ~r[66:0];
        #1 check({7'h00, o_trim_loaded}, 8'h01);
        check({4'h0, o_offset_tempco_order1}, {4'h0, e_ot1});
        check({4'h0, o_offset_tempco_order2}, {4'h0, e_ot2});
        check({1'h0, o_gain_tempco_order0}, {1'h0, e_gt0});
        check({2'h0, o_gain_tempco_order1}, {2'h0, e_gt1});
        check({2'h0, o_gain_tempco_order2}, {2'h0, e_gt2});
    endtask

    task automatic sweep;
        for (int a = 'hac; a <= 'hba; a++) rd(8'(a));
        rd(8'($urandom_range(171, 0)));
    endtask

    initial begin
        void'($urandom(32'hdcd8456e));
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        sweep();
        load('1);
        sweep();
        repeat (24) begin
            load({$urandom, $urandom, $urandom});
            sweep();
        end
        for (int a = 'hac; a <= 'hba; a++) wr(8'(a));
        sweep();
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        {e_gt2, e_gt1, e_gt0, e_ot2, e_ot1} = '0;
        #1 check({7'h00, o_trim_loaded}, 8'h00);
        check({1'h0, o_gain_tempco_order0}, 16'h0000);
        check({4'h0, o_offset_tempco_order1}, 16'h0000);
        sweep();
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule // atb_trim_bank_tb_top
